// ==== irq_compare_assertions.sv ====
// Checker: request compare assertions
`timescale 1ns/1ps
`default_nettype none
module irq_compare_assertions (
    // Watched ports
    input wire logic clk,
    input wire logic rstn,
    input wire logic interrupt_request_n,
    input wire logic [15:0] status,
    input wire logic irq_start,
    input wire logic [3:0] irq_code,
    input wire logic irq_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    start_pulse_a: assert property (irq_start |=> !irq_start) else $error("long start");
    mask_ok_a: assert property (irq_start |-> irq_code <= $past(status[15:12])) else $error("mask");
    pend_first_a: assert property (irq_start |-> $past(irq_pending)) else $error("no pend");
    pend_cause_a: assert property ($rose(irq_pending) |-> !$past(interrupt_request_n, 3)) else $error("pend");
    quiet_idle_a: assert property (interrupt_request_n [*5] |-> !irq_pending) else $error("idle");
    code_hold_a: assert property (interrupt_request_n [*5] |=> $stable(irq_code)) else $error("code");
endmodule : irq_compare_assertions
`default_nettype wire

// ==== irq_compare_pkg.sv ====
// Package: constants for the external interrupt request compare block
`default_nettype none
package irq_compare_pkg;
    localparam int code_width = 4;
    localparam int mask_lsb = 12;
    localparam int mask_msb = 15;
    localparam int status_width = 16;
    localparam logic [3:0] code_reset = 4'h0;
    localparam logic [3:0] code_highest = 4'h1;
    localparam logic [3:0] code_lowest = 4'hf;
    localparam logic [1:0] sync_stages = 2'h2;
    // Request high and code all ones: the pins as they stand with no request
    localparam logic [4:0] pins_idle = 5'h1f;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_compare = 2'b01,
        st_taken = 2'b10
    } irq_state_t;
endpackage : irq_compare_pkg
`default_nettype wire

// ==== irq_encoder_model.sv ====
// Model: external priority encoder
`timescale 1ns/1ps
`default_nettype none
module irq_encoder_model (
    // Bench side and pins
    input wire logic want,
    input wire logic [3:0] level,
    output logic request_n,
    output logic [3:0] code
);
    assign request_n = !want;
    // Idle lines flip so a stray sample shows
    assign code = want ? level : ~level;
endmodule : irq_encoder_model
`default_nettype wire

// ==== irq_request_compare.sv ====
// External interrupt request capture and mask compare
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Request line low asks for interrupt; code inputs captured into holding register.
// R2: Captured code equal or below status mask bits 12..15 starts interrupt sequence.
// R3: Code above mask: request ignored, no interrupt sequence begins.
// R4: Request held after rejection; device keeps resampling and comparing until mask accepts.
// R5: First code input is the MSB; code sampled only while request asserted.
// R6: Far side encodes LLLH as highest priority, HHHH as lowest.
// R7: Request and code sampled on clock; capture and compare in one step.
module irq_request_compare (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Interrupt pins from external priority logic
    input wire logic interrupt_request_n,
    input wire logic priority_code_msb,
    input wire logic priority_code_bit1,
    input wire logic priority_code_bit2,
    input wire logic priority_code_lsb,
    // Processor status register
    input wire logic [irq_compare_pkg::status_width-1:0] status,
    // Interrupt sequence handshake with the processor core
    output logic irq_start,
    output logic [irq_compare_pkg::code_width-1:0] irq_code,
    input wire logic irq_done,
    // Observation
    output logic irq_pending
);
    // Request pin sits above the code pins in the synchroniser word
    localparam int pin_count = irq_compare_pkg::code_width + 1;
    localparam int req_bit = pin_count - 1;

    // Pin path
    logic [irq_compare_pkg::code_width-1:0] code_pins;
    logic [pin_count-1:0] pins_raw;
    logic [pin_count-1:0] pins_sync;

    // Decision terms
    logic req_active;
    logic [irq_compare_pkg::code_width-1:0] code_live;
    logic [irq_compare_pkg::code_width-1:0] mask_value;
    logic code_fits;
    logic accept;

    // Sequencer
    irq_compare_pkg::irq_state_t state_reg;
    irq_compare_pkg::irq_state_t state_next;

    // Code holding register
    logic [irq_compare_pkg::code_width-1:0] code_reg;
    logic [irq_compare_pkg::code_width-1:0] code_next;

    // Start pulse towards the core
    logic start_reg;
    logic start_next;

    // Pending flag, up while a request waits for the mask
    logic pending_reg;
    logic pending_next;

    // The first code input lands in the top bit, so a plain unsigned compare
    // follows the priority order that the far side encodes
    assign code_pins = {priority_code_msb, priority_code_bit1, priority_code_bit2, priority_code_lsb}; // R5
    assign pins_raw = {interrupt_request_n, code_pins};

    // Request and code share one synchroniser, so both reach the decision on the same edge.
    // Limitation: a code that moves while the request is already low can straddle two
    // samples; the far side settles the code before it lowers the request.
    // The idle pattern is all ones, so the request reads inactive straight out of reset.
    pin_sync #(
        .width(pin_count),
        .reset_value(irq_compare_pkg::pins_idle)
    ) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // Request is active low at the pin
    assign req_active = ~pins_sync[req_bit]; // R1 R7
    assign code_live = pins_sync[irq_compare_pkg::code_width-1:0]; // R5 R7
    // Mask comes from core logic on this clock, so it needs no synchroniser
    assign mask_value = status[irq_compare_pkg::mask_msb:irq_compare_pkg::mask_lsb]; // R2

    // Compare uses the live code so capture and decision happen in the same step
    assign code_fits = (code_live <= mask_value); // R2 R3
    assign accept = req_active && code_fits; // R2 R3 R7

    // Latency from the request pin going low to the start pulse is four edges at best:
    // two in the synchroniser, one to enter the compare state and one to compare.
    // A refused request costs nothing extra once the mask is raised.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            irq_compare_pkg::st_idle: begin
                if (req_active) begin
                    // The code is captured on this same edge
                    state_next = irq_compare_pkg::st_compare; // R1
                end else begin
                    state_next = irq_compare_pkg::st_idle;
                end
            end
            irq_compare_pkg::st_compare: begin
                if (!req_active) begin
                    // Request withdrawn before it was accepted
                    state_next = irq_compare_pkg::st_idle;
                end else if (accept) begin
                    state_next = irq_compare_pkg::st_taken; // R2
                end else begin
                    // Refused: stay and compare the resampled code on the next edge
                    state_next = irq_compare_pkg::st_compare; // R3 R4
                end
            end
            irq_compare_pkg::st_taken: begin
                // Holds off a second start until the core finishes the sequence
                if (irq_done) begin
                    state_next = irq_compare_pkg::st_idle;
                end else begin
                    state_next = irq_compare_pkg::st_taken;
                end
            end
            default: begin
                state_next = irq_compare_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= irq_compare_pkg::st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    // Code holding register follows the pins only while it may sample them
    always_comb begin
        code_next = code_reg;
        case (state_reg)
            irq_compare_pkg::st_idle: begin
                if (req_active) begin
                    code_next = code_live; // R1 R5
                end
            end
            irq_compare_pkg::st_compare: begin
                if (req_active) begin
                    // Resampled on every compare edge, so a changed code is judged afresh
                    code_next = code_live; // R4
                end
            end
            irq_compare_pkg::st_taken: begin
                // The accepted code stays put while the core runs its sequence
                code_next = code_reg;
            end
            default: begin
                code_next = code_reg;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            code_reg <= irq_compare_pkg::code_reset;
        end else begin
            code_reg <= code_next;
        end
    end

    // Start pulse lasts one cycle; the taken state keeps it from repeating
    always_comb begin
        start_next = 1'b0;
        case (state_reg)
            irq_compare_pkg::st_compare: begin
                if (accept) begin
                    start_next = 1'b1; // R2
                end
            end
            default: begin
                start_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_next;
        end
    end

    // Pending is registered from the next state so it lines up with the state register
    always_comb begin
        pending_next = 1'b0;
        case (state_next)
            irq_compare_pkg::st_compare: begin
                pending_next = 1'b1; // R4
            end
            default: begin
                pending_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // Outputs come straight from registers
    assign irq_start = start_reg;
    assign irq_code = code_reg;
    assign irq_pending = pending_reg;
endmodule : irq_request_compare
`default_nettype wire

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bus of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int width = 1,
    parameter logic [width-1:0] reset_value = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] meta_reg;
    logic [width-1:0] meta_next;
    logic [width-1:0] sync_reg;
    logic [width-1:0] sync_next;

    // First stage is read only by the second stage
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= reset_value;
            sync_reg <= reset_value;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : pin_sync
`default_nettype wire

// ==== tb_top.sv ====
// Testbench: request compare block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rstn = 0, want = 0, irq_done = 0, irq_start, irq_pending, request_n;
    logic [3:0] level = 4'h0, code, irq_code, n;
    logic [15:0] status = 16'h0000;
    int failures = 0, comparisons = 0, cycles = 0;
    always #2.5 clk = ~clk;
    irq_encoder_model i_irq_encoder_model (.want(want), .level(level), .request_n(request_n), .code(code));
    irq_request_compare i_irq_request_compare (.clk(clk), .rstn(rstn), .interrupt_request_n(request_n),
        .priority_code_msb(code[3]), .priority_code_bit1(code[2]), .priority_code_bit2(code[1]),
        .priority_code_lsb(code[0]), .status(status), .irq_start(irq_start), .irq_code(irq_code),
        .irq_done(irq_done), .irq_pending(irq_pending));
    task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // Request stays up, so a missed or repeated start shows in the count
    task automatic ask(logic [3:0] c, logic [3:0] m, int t);
        @(negedge clk);
        status[15:12] = m;
        level = c;
        want = 1;
        n = 4'h0;
        repeat (t) begin
            @(negedge clk);
            if (irq_start === 1'b1) n++;
        end
    endtask : ask
    task automatic done();
        irq_done = 1;
        want = 0;
        @(negedge clk);
        irq_done = 0;
        repeat (8) @(negedge clk);
    endtask : done
    task automatic each_code();
        for (int c = irq_compare_pkg::code_highest; c <= irq_compare_pkg::code_lowest; c++) begin
            ask(c[3:0], c[3:0], 12);
            check("starts", n, 4'h1);
            check("code", irq_code, c[3:0]);
            done();
        end
    endtask : each_code
    task automatic retry();
        ask(4'h9, 4'h8, 20);
        check("refused", n, 4'h0);
        check("pending", {3'h0, irq_pending}, 4'h1);
        ask(4'h9, 4'h9, 12);
        check("late", n, 4'h1);
        done();
    endtask : retry
    // A refused request that is withdrawn must not start once the mask opens
    task automatic withdraw();
        ask(4'hc, 4'h4, 12);
        check("refused", n, 4'h0);
        want = 0;
        repeat (4) @(negedge clk);
        check("dropped", {3'h0, irq_pending}, 4'h0);
        status[15:12] = 4'hf;
        n = 4'h0;
        repeat (8) begin
            @(negedge clk);
            if (irq_start === 1'b1) n++;
        end
        check("no start", n, 4'h0);
        check("held", irq_code, 4'hc);
        ask(4'h3, 4'hf, 12);
        check("below", n, 4'h1);
        check("code", irq_code, 4'h3);
        done();
    endtask : withdraw
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1;
        each_code();
        retry();
        withdraw();
        wrap_up();
    end
endmodule : tb_top
bind irq_request_compare irq_compare_assertions i_irq_compare_assertions (.clk(clk), .rstn(rstn),
    .interrupt_request_n(interrupt_request_n), .status(status), .irq_start(irq_start),
    .irq_code(irq_code), .irq_pending(irq_pending));
`default_nettype wire
